// ### bench/tb_rcgb_gate_bank.sv
`timescale 1ns/10ps
`default_nettype none

module tb_rcgb_gate_bank;
    import rcgb_pkg::*;

    logic        sys_clk_in;
    logic        rst_in;
    rcgb_req_t   req;
    logic [31:0] rdata;
    rcgb_mode_t  mode;
    logic        auto_sel;
    logic [31:0] sleep_img;
    logic [31:0] deep_img;
    rcgb_acc_t   acc;
    logic [9:0]  clk_en;
    logic        acc_ok;
    logic        bus_fault;
    logic        irq;
    int          n_mismatch;
    int          checks;
    int          cycles;

    rcgb_gate_bank DUT (
        .sys_clk_in                  (sys_clk_in),
        .rst_in                      (rst_in),
        .bus_req_in                  (req),
        .rdata_out                   (rdata),
        .mode_in                     (mode),
        .auto_clock_gating_select_in (auto_sel),
        .sleep_gates_in              (sleep_img),
        .deep_gates_in               (deep_img),
        .acc_in                      (acc),
        .clk_en_out                  (clk_en),
        .acc_ok_out                  (acc_ok),
        .bus_fault_out               (bus_fault),
        .irq_out                     (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock at 40 ns and a cycle limit that cuts a hang short.
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks shared by every test.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Writes the gating register and lets the enables settle.
    task automatic set_run(input logic [31:0] d);
        bus_wr(12'h104, d);
        repeat (2) @(posedge sys_clk_in);
        #1;
    endtask

    // One peripheral access; the answer is judged one cycle later.
    task automatic access(input logic [9:0] sel, input logic fault);
        @(posedge sys_clk_in);
        acc <= '{valid: 1'b1, sel: sel};
        @(posedge sys_clk_in);
        acc.valid <= 1'b0;
        #1;
        check({31'h0, bus_fault}, {31'h0, fault});
        check({31'h0, acc_ok}, {31'h0, !fault});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values of the gating, status and mask registers and the enables, also after a late reset.
    task automatic t_reset();
        logic [31:0] d;
        check({22'h0, clk_en}, 32'h0000_0000);
        bus_rd(12'h104, d);
        check(d, 32'h0000_0000);
        bus_rd(12'h200, d);
        check(d, 32'h0000_0000);
        bus_rd(12'h204, d);
        check(d, 32'h0000_0000);
        access(10'h001, 1'b1);
        $display("test reset done");
    endtask

    // Each gating bit alone drives only its own unit and its own access.
    task automatic t_walk();
        int          pos [10] = '{0, 1, 2, 4, 5, 12, 16, 17, 18, 19};
        logic [31:0] d;
        for (int i = 0; i < 10; i++) begin
            set_run(32'h1 << pos[i]);
            check({22'h0, clk_en}, 32'h1 << i);
            bus_rd(12'h104, d);
            check(d, 32'h1 << pos[i]);
            access(10'h1 << i, 1'b0);
            access(10'h1 << ((i + 1) % 10), 1'b1);
        end
        $display("test walk done");
    endtask

    // Reserved bits read zero and ignore writes; unmapped addresses give zero.
    task automatic t_reserved();
        logic [31:0] d;
        set_run(32'hFFFF_FFFF);
        bus_rd(12'h104, d);
        check(d, 32'h000F_1037);
        check({22'h0, clk_en}, 32'h0000_03FF);
        set_run(32'hFFF0_EFC8);
        bus_rd(12'h104, d);
        check(d, 32'h0000_0000);
        check({22'h0, clk_en}, 32'h0000_0000);
        bus_wr(12'h100, 32'hFFFF_FFFF);
        bus_rd(12'h104, d);
        check(d, 32'h0000_0000);
        bus_rd(12'h108, d);
        check(d, 32'h0000_0000);
        bus_rd(12'h104, d);
        set_run(d | 32'h0000_1000);
        bus_rd(12'h104, d);
        check(d, 32'h0000_1000);
        check({22'h0, clk_en}, 32'h0000_0020);
        $display("test reserved done");
    endtask

    // A fault is latched, raises the interrupt when unmasked, then clears.
    task automatic t_irq();
        logic [31:0] d;
        bus_wr(12'h200, 32'h0000_0003);
        access(10'h010, 1'b1);
        bus_rd(12'h208, d);
        check(d, 32'h0000_0010);
        bus_rd(12'h200, d);
        check(d & 32'h1, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        bus_wr(12'h204, 32'h0000_0001);
        repeat (2) @(posedge sys_clk_in);
        #1 check({31'h0, irq}, 32'h0000_0001);
        bus_wr(12'h200, 32'h0000_0003);
        repeat (2) @(posedge sys_clk_in);
        #1 check({31'h0, irq}, 32'h0000_0000);
        bus_wr(12'h204, 32'h0000_0000);
        set_run(32'h0000_0001);
        bus_rd(12'h200, d);
        check(d, 32'h0000_0002);
        $display("test irq done");
    endtask

    // Low power uses the sleep images only when automatic gating is on.
    task automatic t_modes();
        set_run(32'h000F_1037);
        @(posedge sys_clk_in);
        sleep_img <= 32'h000A_1025;
        deep_img  <= 32'h0005_0012;
        mode      <= RCGB_SLEEP;
        repeat (3) @(posedge sys_clk_in);
        #1 check({22'h0, clk_en}, 32'h0000_03FF);
        @(posedge sys_clk_in);
        auto_sel <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #1 check({22'h0, clk_en}, 32'h0000_02B5);
        @(posedge sys_clk_in);
        mode <= RCGB_DEEP;
        repeat (3) @(posedge sys_clk_in);
        #1 check({22'h0, clk_en}, 32'h0000_014A);
        access(10'h002, 1'b0);
        access(10'h001, 1'b1);
        @(posedge sys_clk_in);
        mode <= RCGB_RUN;
        repeat (3) @(posedge sys_clk_in);
        #1 check({22'h0, clk_en}, 32'h0000_03FF);
        @(posedge sys_clk_in);
        auto_sel <= 1'b0;
        $display("test modes done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence, with a second reset in mid-run.
    initial begin
        n_mismatch = 0;
        checks     = 0;
        cycles     = 0;
        rst_in     = 1'b1;
        req        = '0;
        mode       = RCGB_RUN;
        auto_sel   = 1'b0;
        sleep_img  = 32'h0000_0000;
        deep_img   = 32'h0000_0000;
        acc        = '0;
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_walk();
        t_reserved();
        t_irq();
        t_modes();
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_reset();
        print_verdict();
    end
endmodule

`default_nettype wire

// ### core/rcgb_gate_bank.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module rcgb_gate_bank (
    input  wire logic                           sys_clk_in,
    input  wire logic                           rst_in,
    input  wire rcgb_pkg::rcgb_req_t            bus_req_in,
    output var  logic [31:0]                    rdata_out,
    input  wire rcgb_pkg::rcgb_mode_t           mode_in,
    input  wire logic                           auto_clock_gating_select_in,
    input  wire logic [31:0]                    sleep_gates_in,
    input  wire logic [31:0]                    deep_gates_in,
    input  wire rcgb_pkg::rcgb_acc_t            acc_in,
    output var  logic [rcgb_pkg::RCGB_UNITS-1:0] clk_en_out,
    output var  logic                           acc_ok_out,
    output var  logic                           bus_fault_out,
    output var  logic                           irq_out
);
    import rcgb_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [31:0]             run_clock_gate_enables_1;
    logic [RCGB_EVENTS-1:0]  status;
    logic [RCGB_EVENTS-1:0]  mask;
    logic [RCGB_UNITS-1:0]   fault_unit;
    logic [RCGB_UNITS-1:0]   run_units;
    logic [RCGB_UNITS-1:0]   next_clk_en;
    logic [RCGB_EVENTS-1:0]  events;
    logic                    wr_run;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    fault_now;
    logic [31:0]             next_rdata;

    //////////////////////////////////////////////////////////////////////////
    // Address decode of the write strobe.

    // Each write hits at most one register; unmapped writes are dropped.
    assign wr_run    = bus_req_in.wr &&
                       (bus_req_in.addr == RCGB_RUN_OFS);
    assign wr_status = bus_req_in.wr && (bus_req_in.addr == RCGB_STATUS_OFS);
    assign wr_mask   = bus_req_in.wr && (bus_req_in.addr == RCGB_MASK_OFS);

    //////////////////////////////////////////////////////////////////////////
    // Gating register.

    // Only the documented gating bits are stored; the rest stay zero.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_clock_gate_enables_1 <= RCGB_RUN_RESET;
        end else if (wr_run) begin
            run_clock_gate_enables_1 <= bus_req_in.wdata & RCGB_WMASK;
        end
    end

    // Gating bits gathered in unit order.
    assign run_units = rcgb_units(run_clock_gate_enables_1);

    //////////////////////////////////////////////////////////////////////////
    // Selection of the settings in force for the power state.

    // The run settings hold while running, and also in low power unless
    // automatic gating is selected.
    always_comb begin
        next_clk_en = run_units;
        if (auto_clock_gating_select_in) begin
            case (mode_in)
                RCGB_RUN: begin
                    next_clk_en = run_units;
                end
                RCGB_SLEEP: begin
                    next_clk_en = rcgb_units(sleep_gates_in);
                end
                RCGB_DEEP: begin
                    next_clk_en = rcgb_units(deep_gates_in);
                end
                default: begin
                    next_clk_en = run_units;
                end
            endcase
        end
    end

    // Enables leave a flip-flop so a clock gate cell on the unit side sees
    // them change only just after a system clock edge.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_en_out <= RCGB_EN_RESET;
        end else begin
            clk_en_out <= next_clk_en;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Access checking.

    // An access is faulted when its target unit has no clock enable.
    assign fault_now = acc_in.valid && ((acc_in.sel & clk_en_out) == '0);

    // The answer to an access comes one cycle after it.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_ok_out    <= 1'b0;
            bus_fault_out <= 1'b0;
        end else begin
            acc_ok_out    <= acc_in.valid && !fault_now;
            bus_fault_out <= fault_now;
        end
    end

    // The unit of the last faulted access is kept for software.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_unit <= RCGB_EN_RESET;
        end else if (fault_now) begin
            fault_unit <= acc_in.sel;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    // Events: a faulted access, and any change of the enables in force.
    assign events[RCGB_EV_FAULT]  = fault_now;
    assign events[RCGB_EV_CHANGE] = (next_clk_en != clk_en_out);

    // Sticky bits, cleared by writing one; a new event beats the clear.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status <= RCGB_EV_RESET;
        end else if (wr_status) begin
            status <= (status & ~bus_req_in.wdata[RCGB_EVENTS-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    // Mask register of the same layout.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask <= RCGB_EV_RESET;
        end else if (wr_mask) begin
            mask <= bus_req_in.wdata[RCGB_EVENTS-1:0];
        end
    end

    // Level interrupt while any unmasked status bit is set.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status & mask);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path.

    // Read data for the addressed register; unmapped addresses give zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                RCGB_RUN_OFS: begin
                    next_rdata = run_clock_gate_enables_1;
                end
                RCGB_STATUS_OFS: begin
                    next_rdata[RCGB_EVENTS-1:0] = status;
                end
                RCGB_MASK_OFS: begin
                    next_rdata[RCGB_EVENTS-1:0] = mask;
                end
                RCGB_FAULT_OFS: begin
                    next_rdata[RCGB_UNITS-1:0] = fault_unit;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Reserved bits never hold a one.
    property p_reserved_zero;
        (run_clock_gate_enables_1 & ~RCGB_WMASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved gating bit is set");

    // Gating register is clear at the first edge after reset.
    property p_reset_clear;
        $fell(rst_in) |-> (run_clock_gate_enables_1 == RCGB_RUN_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("gating register not clear after reset");

    // A write stores exactly the writable bits of the data.
    property p_write_store;
        wr_run |=> run_clock_gate_enables_1 ==
            ($past(bus_req_in.wdata) & RCGB_WMASK);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("gating write not stored");

    // Counter unit 3 follows bit 19 of the written data.
    property p_cnt3_bit;
        wr_run && !auto_clock_gating_select_in ##1
            !auto_clock_gating_select_in |=>
            clk_en_out[RCGB_UNITS-1] == $past(bus_req_in.wdata[19], 2);
    endproperty
    a_cnt3_bit: assert property (p_cnt3_bit)
        else $error("counter unit 3 enable wrong");

    // Reading the gating register returns its value in the next cycle.
    property p_read_run;
        bus_req_in.rd && bus_req_in.addr == RCGB_RUN_OFS |=>
            rdata_out == $past(run_clock_gate_enables_1);
    endproperty
    a_read_run: assert property (p_read_run)
        else $error("gating register read wrong");

    // An access to an unclocked unit faults in the next cycle.
    property p_fault;
        acc_in.valid && ((acc_in.sel & clk_en_out) == '0) |=>
            bus_fault_out && !acc_ok_out;
    endproperty
    a_fault: assert property (p_fault)
        else $error("missing bus fault");

    // An access to a clocked unit completes normally.
    property p_no_fault;
        acc_in.valid && ((acc_in.sel & clk_en_out) != '0) |=>
            acc_ok_out && !bus_fault_out;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("clocked unit faulted");

    // While running, the enables follow the gating register.
    property p_run_gate;
        mode_in == RCGB_RUN |=> clk_en_out == $past(run_units);
    endproperty
    a_run_gate: assert property (p_run_gate)
        else $error("run enables wrong");

    // Without auto gating, low power keeps the run settings.
    property p_no_auto;
        !auto_clock_gating_select_in |=> clk_en_out == $past(run_units);
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("low power ignored run settings");

    // With auto gating, sleep uses the sleep settings.
    property p_sleep_auto;
        auto_clock_gating_select_in && mode_in == RCGB_SLEEP |=>
            clk_en_out == $past(rcgb_units(sleep_gates_in));
    endproperty
    a_sleep_auto: assert property (p_sleep_auto)
        else $error("sleep enables wrong");

    // A fault event sets its sticky bit even under a clearing write.
    property p_fault_sticky;
        fault_now |=> status[RCGB_EV_FAULT] ##1 irq_out == $past(
            |(status & mask));
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault status lost");

    // Enables change only after a clock edge and stay for a cycle.
    property p_stable_en;
        (next_clk_en == clk_en_out) |=> $stable(clk_en_out);
    endproperty
    a_stable_en: assert property (p_stable_en)
        else $error("enable changed without cause");

    // With auto gating, deep sleep uses the deep sleep settings.
    property p_deep_auto;
        auto_clock_gating_select_in && mode_in == RCGB_DEEP |=>
            clk_en_out == $past(rcgb_units(deep_gates_in));
    endproperty
    a_deep_auto: assert property (p_deep_auto)
        else $error("deep sleep enables wrong");

    // Read data stay zero in any cycle that does not follow a read.
    property p_rdata_idle;
        !bus_req_in.rd |=> rdata_out == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");

    // While running, two-wire unit 0 follows bit 12 of the register.
    property p_twi0_bit;
        mode_in == RCGB_RUN |=> clk_en_out[5] ==
            $past(run_clock_gate_enables_1[RCGB_TWI0_POS]);
    endproperty
    a_twi0_bit: assert property (p_twi0_bit)
        else $error("two-wire unit 0 enable wrong");

    // While running, sync serial unit 1 follows bit 5 of the register.
    property p_ss1_bit;
        mode_in == RCGB_RUN |=> clk_en_out[4] ==
            $past(run_clock_gate_enables_1[RCGB_SS1_POS]);
    endproperty
    a_ss1_bit: assert property (p_ss1_bit)
        else $error("sync serial unit 1 enable wrong");

    // Cover a faulted access, a normal access, a sleep transition and a raised interrupt.
    c_fault: cover property (acc_in.valid ##1 bus_fault_out);
    c_ok: cover property (wr_run ##[1:8] acc_in.valid ##1 acc_ok_out);
    c_sleep: cover property (auto_clock_gating_select_in &&
        mode_in == RCGB_SLEEP ##1 clk_en_out != run_units);
    c_irq: cover property (irq_out);

endmodule

`default_nettype wire

// ### core/rcgb_pkg.sv
`default_nettype none

package rcgb_pkg;

    // Register offsets within the system control block.
    localparam logic [11:0] RCGB_RUN_OFS    = 12'h104;
    localparam logic [11:0] RCGB_STATUS_OFS = 12'h200;
    localparam logic [11:0] RCGB_MASK_OFS   = 12'h204;
    localparam logic [11:0] RCGB_FAULT_OFS  = 12'h208;

    // Value of the gating register after reset: every unit unclocked.
    localparam logic [31:0] RCGB_RUN_RESET  = 32'h0000_0000;

    // Bits that software may change; all others read as zero.
    localparam logic [31:0] RCGB_WMASK      = 32'h000F_1037;

    // Field positions of the gating bits.
    localparam int RCGB_CNT3_POS = 19;
    localparam int RCGB_CNT2_POS = 18;
    localparam int RCGB_CNT1_POS = 17;
    localparam int RCGB_CNT0_POS = 16;
    localparam int RCGB_TWI0_POS = 12;
    localparam int RCGB_SS1_POS  = 5;
    localparam int RCGB_SS0_POS  = 4;
    localparam int RCGB_AS2_POS  = 2;
    localparam int RCGB_AS1_POS  = 1;
    localparam int RCGB_AS0_POS  = 0;

    // Number of controlled units and interrupt event bits.
    localparam int RCGB_UNITS  = 10;
    localparam int RCGB_EVENTS = 2;

    // Event bit positions in the status and mask registers.
    localparam int RCGB_EV_FAULT  = 0;
    localparam int RCGB_EV_CHANGE = 1;

    // Reset values of the side registers.
    localparam logic [RCGB_EVENTS-1:0] RCGB_EV_RESET = 2'h0;
    localparam logic [RCGB_UNITS-1:0]  RCGB_EN_RESET = 10'h000;

    // Power state of the system.
    typedef enum logic [1:0] {
        RCGB_RUN,
        RCGB_SLEEP,
        RCGB_DEEP
    } rcgb_mode_t;

    // One register bus request.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rcgb_req_t;

    // One access aimed at a peripheral unit, select is one-hot.
    typedef struct packed {
        logic                  valid;
        logic [RCGB_UNITS-1:0] sel;
    } rcgb_acc_t;

    // Gathers the gating bits of a register image into unit order.
    function automatic logic [RCGB_UNITS-1:0] rcgb_units(
        input logic [31:0] r);
        rcgb_units = {r[RCGB_CNT3_POS], r[RCGB_CNT2_POS],
                      r[RCGB_CNT1_POS], r[RCGB_CNT0_POS],
                      r[RCGB_TWI0_POS], r[RCGB_SS1_POS],
                      r[RCGB_SS0_POS],  r[RCGB_AS2_POS],
                      r[RCGB_AS1_POS],  r[RCGB_AS0_POS]};
    endfunction

endpackage

`default_nettype wire
